// *** hdl/dcf_pkg.sv ***
package dcf_pkg;
  localparam int unsigned RAM_AW = 8;
  // RAM word offsets
  localparam logic [7:0] OFS_OPEN_CIRCUIT = 8'h00;
  localparam logic [7:0] OFS_OFFHOOK_OFFSET = 8'h01;
  localparam logic [7:0] OFS_LOWER_THRESHOLD = 8'h02;
  localparam logic [7:0] OFS_UPPER_THRESHOLD = 8'h03;
  localparam logic [7:0] OFS_COMMON_MODE = 8'h04;
  localparam logic [7:0] OFS_LOOP_SENSE = 8'h07;
  localparam logic [7:0] OFS_BATTERY = 8'h0d;
  // Field layout of the 15-bit programmed voltages
  localparam int unsigned NARROW_MSB = 14;
  // Reset values; one step is 4.907 mV
  localparam logic [15:0] RST_OPEN_CIRCUIT = 16'h0000;
  localparam logic [15:0] RST_OFFHOOK_OFFSET = 16'h0000;
  localparam logic [15:0] RST_COMMON_MODE = 16'h0000;
  localparam logic [15:0] RST_BATTERY = 16'h0000;
  localparam logic [15:0] RST_LOOP_SENSE = 16'h0000;
  // 2 V is 408 steps
  localparam logic [15:0] RST_UPPER_THRESHOLD = 16'h0198;
  // -8 V is -1630 steps, two's complement
  localparam logic [15:0] RST_LOWER_THRESHOLD = 16'hf9a2;
  typedef enum logic [1:0] {
    ST_ONHOOK = 2'b01,
    ST_OFFHOOK = 2'b10
  } dcf_hook_e;
endpackage

// *** hdl/dcf_feed_params.sv ***
`timescale 1ns/1ps
module dcf_feed_params
  import dcf_pkg::*;
#(
  parameter int unsigned DATA_W = 16
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RESETN,
  input wire logic [RAM_AW-1:0] I_RAM_ADDR,
  input wire logic I_RAM_WR,
  input wire logic I_RAM_RD,
  input wire logic [DATA_W-1:0] I_RAM_WDATA,
  output logic [DATA_W-1:0] O_RAM_RDATA,
  output logic O_RAM_RVALID,
  input wire logic I_BAT_SAMPLE_VALID,
  input wire logic [DATA_W-1:0] I_BAT_SAMPLE,
  input wire logic I_LOOP_SAMPLE_VALID,
  input wire logic [DATA_W-1:0] I_LOOP_SAMPLE,
  output logic [DATA_W-1:0] O_VOC_TARGET,
  output logic [DATA_W-1:0] O_COMMON_MODE,
  output logic O_OFFSET_ACTIVE
);

  logic [DATA_W-1:0] open_circuit_voltage;
  logic [DATA_W-1:0] offhook_offset_voltage;
  logic [DATA_W-1:0] offset_lower_threshold;
  logic [DATA_W-1:0] offset_upper_threshold;
  logic [DATA_W-1:0] common_mode_voltage;
  logic [DATA_W-1:0] loop_voltage_sense;
  logic [DATA_W-1:0] battery_voltage_reading;
  dcf_hook_e hook_state;
  dcf_hook_e next_hook_state;
  logic [DATA_W-1:0] narrow_mask;
  logic signed [DATA_W+1:0] loop_s;
  logic signed [DATA_W+1:0] lower_trip;
  logic signed [DATA_W+1:0] upper_trip;
  logic [DATA_W-1:0] next_rdata;

  assign narrow_mask = {{(DATA_W-NARROW_MSB-1){1'b0}}, {(NARROW_MSB+1){1'b1}}};

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      common_mode_voltage <= RST_COMMON_MODE;
    end else if (I_RAM_WR && I_RAM_ADDR == OFS_COMMON_MODE) begin
      common_mode_voltage <= I_RAM_WDATA & narrow_mask;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      open_circuit_voltage <= RST_OPEN_CIRCUIT;
    end else if (I_RAM_WR && I_RAM_ADDR == OFS_OPEN_CIRCUIT) begin
      open_circuit_voltage <= I_RAM_WDATA & narrow_mask;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      offhook_offset_voltage <= RST_OFFHOOK_OFFSET;
    end else if (I_RAM_WR && I_RAM_ADDR == OFS_OFFHOOK_OFFSET) begin
      offhook_offset_voltage <= I_RAM_WDATA & narrow_mask;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      offset_lower_threshold <= RST_LOWER_THRESHOLD;
    end else if (I_RAM_WR && I_RAM_ADDR == OFS_LOWER_THRESHOLD) begin
      offset_lower_threshold <= I_RAM_WDATA;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      offset_upper_threshold <= RST_UPPER_THRESHOLD;
    end else if (I_RAM_WR && I_RAM_ADDR == OFS_UPPER_THRESHOLD) begin
      offset_upper_threshold <= I_RAM_WDATA;
    end
  end

  // battery sample, converter wins over host write
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      battery_voltage_reading <= RST_BATTERY;
    end else if (I_BAT_SAMPLE_VALID) begin
      battery_voltage_reading <= I_BAT_SAMPLE;
    end else if (I_RAM_WR && I_RAM_ADDR == OFS_BATTERY) begin
      battery_voltage_reading <= I_RAM_WDATA;
    end
  end

  // loop sample, converter wins over host write
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      loop_voltage_sense <= RST_LOOP_SENSE;
    end else if (I_LOOP_SAMPLE_VALID) begin
      loop_voltage_sense <= I_LOOP_SAMPLE;
    end else if (I_RAM_WR && I_RAM_ADDR == OFS_LOOP_SENSE) begin
      loop_voltage_sense <= I_RAM_WDATA;
    end
  end

  // Thresholds are signed step counts; two guard bits keep the sums exact
  assign loop_s = signed'({2'b00, loop_voltage_sense});
  assign lower_trip = signed'({2'b00, open_circuit_voltage})
                    + signed'({{2{offset_lower_threshold[DATA_W-1]}}, offset_lower_threshold});
  assign upper_trip = signed'({2'b00, open_circuit_voltage})
                    + signed'({{2{offset_upper_threshold[DATA_W-1]}}, offset_upper_threshold});

  always_comb begin
    next_hook_state = hook_state;
    case (hook_state)
      ST_ONHOOK: begin
        if (loop_s < lower_trip) begin
          next_hook_state = ST_OFFHOOK;
        end
      end
      ST_OFFHOOK: begin
        if (loop_s > upper_trip) begin
          next_hook_state = ST_ONHOOK;
        end
      end
      default: begin
        next_hook_state = ST_ONHOOK;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      hook_state <= ST_ONHOOK;
    end else begin
      hook_state <= next_hook_state;
    end
  end

  // offset applied while off-hook
  // Both fields are 15 bits wide, so the sum cannot carry out of the word
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_VOC_TARGET <= RST_OPEN_CIRCUIT;
    end else if (next_hook_state == ST_OFFHOOK) begin
      O_VOC_TARGET <= DATA_W'(open_circuit_voltage + offhook_offset_voltage);
    end else begin
      O_VOC_TARGET <= open_circuit_voltage;
    end
  end

  // hook flag from entered state
  // Taken from the next state so the flag and the target move on one edge
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_OFFSET_ACTIVE <= 1'b0;
    end else begin
      O_OFFSET_ACTIVE <= (next_hook_state == ST_OFFHOOK);
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_COMMON_MODE <= RST_COMMON_MODE;
    end else begin
      O_COMMON_MODE <= common_mode_voltage;
    end
  end

  // Unmapped addresses read as zero
  always_comb begin
    if (I_RAM_ADDR == OFS_OPEN_CIRCUIT) begin
      next_rdata = open_circuit_voltage;
    end else if (I_RAM_ADDR == OFS_OFFHOOK_OFFSET) begin
      next_rdata = offhook_offset_voltage;
    end else if (I_RAM_ADDR == OFS_LOWER_THRESHOLD) begin
      next_rdata = offset_lower_threshold;
    end else if (I_RAM_ADDR == OFS_UPPER_THRESHOLD) begin
      next_rdata = offset_upper_threshold;
    end else if (I_RAM_ADDR == OFS_COMMON_MODE) begin
      next_rdata = common_mode_voltage;
    end else if (I_RAM_ADDR == OFS_LOOP_SENSE) begin
      next_rdata = loop_voltage_sense;
    end else if (I_RAM_ADDR == OFS_BATTERY) begin
      next_rdata = battery_voltage_reading;
    end else begin
      next_rdata = '0;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_RAM_RVALID <= 1'b0;
    end else begin
      O_RAM_RVALID <= I_RAM_RD;
    end
  end

  // Data holds until the next read, so a slow host may pick it up late
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_RAM_RDATA <= '0;
    end else if (I_RAM_RD) begin
      O_RAM_RDATA <= next_rdata;
    end
  end

endmodule // dcf_feed_params

// *** tb/dcf_feed_params_properties.sv ***
`timescale 1ns/1ps
module dcf_chk
  import dcf_pkg::*;
#(
  parameter int unsigned DATA_W = 16
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RESETN,
  input wire logic [RAM_AW-1:0] I_RAM_ADDR,
  input wire logic I_RAM_WR,
  input wire logic I_RAM_RD,
  input wire logic [DATA_W-1:0] I_RAM_WDATA,
  input wire logic [DATA_W-1:0] O_RAM_RDATA,
  input wire logic O_RAM_RVALID,
  input wire logic I_BAT_SAMPLE_VALID,
  input wire logic [DATA_W-1:0] I_BAT_SAMPLE,
  input wire logic I_LOOP_SAMPLE_VALID,
  input wire logic [DATA_W-1:0] I_LOOP_SAMPLE,
  input wire logic [DATA_W-1:0] O_VOC_TARGET,
  input wire logic [DATA_W-1:0] O_COMMON_MODE,
  input wire logic O_OFFSET_ACTIVE
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);
  // Hook state may only move after a loop sample or a host write
  logic cause;
  assign cause = I_LOOP_SAMPLE_VALID || I_RAM_WR;
  read_answer_a: assert property (I_RAM_RD |=> O_RAM_RVALID) else $error("read unanswered");
  rvalid_cause_a: assert property (O_RAM_RVALID |-> $past(I_RAM_RD)) else $error("stray rvalid");
  battery_read_a: assert property (I_BAT_SAMPLE_VALID ##1 (I_RAM_RD && I_RAM_ADDR == 8'h0d)
    |=> O_RAM_RDATA == $past(I_BAT_SAMPLE, 2)) else $error("battery word wrong");
  loop_read_a: assert property (I_LOOP_SAMPLE_VALID ##1 (I_RAM_RD && I_RAM_ADDR == 8'h07)
    |=> O_RAM_RDATA == $past(I_LOOP_SAMPLE, 2)) else $error("loop word wrong");
  cm_narrow_a: assert property (O_COMMON_MODE[15] == 1'b0) else $error("common mode bit 15");
  target_narrow_a: assert property (!O_OFFSET_ACTIVE |-> O_VOC_TARGET[15] == 1'b0)
    else $error("on-hook target bit 15");
  offset_rise_a: assert property ($rose(O_OFFSET_ACTIVE) |-> $past(cause, 2) || $past(cause, 3))
    else $error("offset added without cause");
  offset_fall_a: assert property ($fell(O_OFFSET_ACTIVE) |-> $past(cause, 2) || $past(cause, 3))
    else $error("offset removed without cause");
  narrow_read_a: assert property (O_RAM_RVALID && $past(I_RAM_ADDR) inside {8'h00, 8'h01, 8'h04}
    |-> !O_RAM_RDATA[15]) else $error("narrow word bit 15");
endmodule // dcf_chk
bind dcf_feed_params dcf_chk #(.DATA_W(DATA_W)) dcf_chk_inst (.*);

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import dcf_pkg::*;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, bv = 0, lv = 0, rv, act;
  logic [7:0] addr = 0;
  logic [15:0] wd = 0, bs = 0, ls = 0, rdata, tgt, cm;
  int n_errors = 0, tests_run = 0, off, m[64];
  int ra[8] = '{0, 1, 2, 3, 4, 7, 13, 32};
  int lu[4] = '{8758, 8757, 10806, 10807};
  int lt[6] = '{8152, 8151, 1000, 10190, 10191, 20000};
  always #20 clk = ~clk;
  dcf_feed_params dcf_feed_params_inst (.I_CORE_CLK(clk), .I_RESETN(rstn), .I_RAM_ADDR(addr),
    .I_RAM_WR(wr), .I_RAM_RD(rd), .I_RAM_WDATA(wd), .O_RAM_RDATA(rdata), .O_RAM_RVALID(rv),
    .I_BAT_SAMPLE_VALID(bv), .I_BAT_SAMPLE(bs), .I_LOOP_SAMPLE_VALID(lv), .I_LOOP_SAMPLE(ls),
    .O_VOC_TARGET(tgt), .O_COMMON_MODE(cm), .O_OFFSET_ACTIVE(act));
  task automatic chk(logic [15:0] s, logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic print_verdict;
    $display("compares=%0d mismatches=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic int sx(int x);
    return x > 32767 ? x - 65536 : x;
  endfunction
  task automatic reset;
    rstn = 0;
    repeat (2) @(posedge clk);
    #1 rstn = 1;
    m = '{default: 0};
    m[2] = 'hf9a2;
    m[3] = 'h198;
    off = 0;
  endtask
  task automatic wr_word(int a, int d);
    @(posedge clk);
    #1 {wr, addr, wd} = {1'b1, 8'(a), 16'(d)};
    @(posedge clk);
    #1 wr = 0;
    if (a inside {0, 1, 2, 3, 4, 7, 13}) m[a] = d & ((a inside {0, 1, 4}) ? 'h7fff : 'hffff);
  endtask
  task automatic rd_word(int a);
    @(posedge clk);
    #1 {rd, addr} = {1'b1, 8'(a)};
    @(posedge clk);
    #1 rd = 0;
    chk({15'h0, rv}, 16'h1);
    chk(rdata, 16'(m[a]));
  endtask
  // Read-back rides the cycle after the sample; hook outputs settle on the same edge as the read data
  task automatic samp(bit bat, int v);
    v = v & 'hffff;
    @(posedge clk);
    #1 {bv, lv, bs, ls} = {bat, !bat, 16'(v), 16'(v)};
    @(posedge clk);
    #1 {bv, lv, rd, addr} = {2'b00, 1'b1, 8'(bat ? 13 : 7)};
    m[bat ? 13 : 7] = v & 'hffff;
    if (!bat && !off && v < m[0] + sx(m[2])) off = 1;
    else if (!bat && off && v > m[0] + sx(m[3])) off = 0;
    @(posedge clk);
    #1 rd = 0;
    chk(rdata, 16'(m[bat ? 13 : 7]));
    @(posedge clk);
    #1;
  endtask
  task automatic hook_chk;
    chk({15'h0, act}, 16'(off));
    chk(tgt, 16'(m[0] + (off ? m[1] : 0)));
    chk(cm, 16'(m[4]));
  endtask
  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end
  initial begin
    void'($urandom(70869));
    reset();
    foreach (ra[i]) rd_word(ra[i]);
    $display("test reset values done");
    // Lower threshold negative, upper positive: the trip points never cross
    foreach (ra[i]) wr_word(ra[i], ra[i] == 3 ? $urandom & 'h7fff : $urandom | 'h8000);
    foreach (ra[i]) rd_word(ra[i]);
    $display("test write readback done");
    repeat (4) samp(1'b1, $urandom);
    repeat (4) samp(1'b0, $urandom);
    $display("test samples done");
    reset();
    samp(1'b0, 32767);
    wr_word(0, 'h2636);
    wr_word(1, 'h0593);
    wr_word(4, 'h0263);
    foreach (lt[i]) begin
      samp(1'b0, lt[i]);
      hook_chk();
    end
    wr_word(2, 'hfc00);
    wr_word(3, 'h0400);
    foreach (lu[i]) begin
      samp(1'b0, lu[i]);
      hook_chk();
    end
    $display("test hook hysteresis done");
    print_verdict();
  end
endmodule // tb_top
